// >>> rtl/uef_ext_regs.sv
// Extended-feature register set of the UART with unlock gating
`timescale 1ns/1ps
module uef_ext_regs
   import uef_pkg::*;
#(
   parameter logic [7:0] EXT_FEATURE_RESET = UEF_RST_EXT_FEATURE,
   parameter logic [7:0] PRESCALER_RESET = UEF_RST_PRESCALER
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] lineCtrl,
   input wire logic regSel,
   input wire logic regRd,
   input wire logic regWr,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic regRvalid,
   input uef_pkg::uef_core_stat_t coreStat,
   input uef_pkg::uef_flow_evt_t flowEvt,
   input wire logic txActive,
   input wire logic txShiftBusy,
   input wire logic modemRts,
   output uef_pkg::uef_ctrl_t ctrl,
   output logic rtsOut,
   output logic txStop
);
   import uef_pkg::*;

   logic [7:0] extFeature_q;
   logic [7:0] specialFn_q;
   logic [7:0] unlockKey_q;
   logic [7:0] prescaler_q;
   logic [7:0] idleTime_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic rxEnable_q;
   logic [7:0] flowStatus;

   // Burst addressing state
   logic [3:0] nextAddr_q;
   logic inBurst_q;
   logic [3:0] curAddr;

   // Access windows
   logic lcrOpen;
   logic sfOpen;
   logic specOpen;
   logic access;

   assign lcrOpen = (lineCtrl == UEF_LCR_UNLOCK);
   assign sfOpen = lcrOpen && (unlockKey_q == UEF_KEY_VALUE);
   assign specOpen = lcrOpen && specialFn_q[UEF_SF_SPECIAL_ACC];
   assign access = regSel && (regRd || regWr);

   // Later accesses of one transaction step to the next register
   always_comb begin
      if (inBurst_q && specialFn_q[UEF_SF_BURST]) begin
         curAddr = nextAddr_q;
      end else begin
         curAddr = regAddr;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         inBurst_q <= 1'b0;
      end else if (!regSel) begin
         inBurst_q <= 1'b0;
      end else if (access) begin
         inBurst_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         nextAddr_q <= 4'h0;
      end else if (access) begin
         nextAddr_q <= curAddr + 4'h1;
      end
   end

   // Unlock key
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         unlockKey_q <= UEF_RST_UNLOCK_KEY;
      end else if (regWr && regSel && lcrOpen && curAddr == UEF_OFS_UNLOCK_KEY) begin
         unlockKey_q <= regWdata;
      end
   end

   // Special function register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         specialFn_q <= UEF_RST_SPECIAL_FN;
      end else if (regWr && regSel && sfOpen && curAddr == UEF_OFS_SPECIAL_FN) begin
         specialFn_q <= regWdata & UEF_SPECIAL_FN_MASK;
      end
   end

   // Extended feature control
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         extFeature_q <= EXT_FEATURE_RESET & UEF_EXT_FEATURE_MASK;
      end else if (regWr && regSel && lcrOpen && !specOpen
            && curAddr == UEF_OFS_EXT_FEATURE) begin
         extFeature_q <= regWdata & UEF_EXT_FEATURE_MASK;
      end
   end

   // Receiver enable in its own flop so the output needs no inverter
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rxEnable_q <= ~EXT_FEATURE_RESET[UEF_EF_RX_DIS];
      end else if (regWr && regSel && lcrOpen && !specOpen
            && curAddr == UEF_OFS_EXT_FEATURE) begin
         rxEnable_q <= ~regWdata[UEF_EF_RX_DIS];
      end
   end

   // Baud prescaler M and N
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prescaler_q <= PRESCALER_RESET;
      end else if (regWr && regSel && specOpen && curAddr == UEF_OFS_PRESCALER) begin
         prescaler_q <= regWdata;
      end
   end

   // Transmit idle time count
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         idleTime_q <= UEF_RST_IDLE_TIME;
      end else if (regWr && regSel && specOpen && curAddr == UEF_OFS_IDLE_TIME) begin
         idleTime_q <= regWdata;
      end
   end

   // Read path, one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (regRd && regSel) begin
         rdata_q <= 8'h00;
         if (lcrOpen) begin
            case (curAddr)
               UEF_OFS_UNLOCK_KEY: begin
                  rdata_q <= unlockKey_q;
               end
               UEF_OFS_SPECIAL_FN: begin
                  if (sfOpen) begin
                     rdata_q <= specialFn_q;
                  end
               end
               UEF_OFS_EXT_FEATURE: begin
                  if (!specOpen) begin
                     rdata_q <= extFeature_q;
                  end
               end
               UEF_OFS_FLOW_STATUS: begin
                  if (specOpen) begin
                     rdata_q <= flowStatus;
                  end
               end
               UEF_OFS_PRESCALER: begin
                  if (specOpen) begin
                     rdata_q <= prescaler_q;
                  end
               end
               UEF_OFS_RX_COUNT: begin
                  if (specOpen && !specialFn_q[UEF_SF_CNT_SEL]) begin
                     rdata_q <= coreStat.rxCount;
                  end else if (specOpen) begin
                     rdata_q <= coreStat.errCount;
                  end
               end
               UEF_OFS_TX_COUNT: begin
                  if (specOpen) begin
                     rdata_q <= coreStat.txCount;
                  end
               end
               UEF_OFS_IDLE_TIME: begin
                  if (specOpen) begin
                     rdata_q <= idleTime_q;
                  end
               end
               default: begin
                  rdata_q <= 8'h00;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= regRd && regSel;
      end
   end

   assign regRdata = rdata_q;
   assign regRvalid = rvalid_q;

   // Control outputs straight from the register flops
   assign ctrl.irdaQuarter = extFeature_q[UEF_EF_IRDA_WIDE];
   assign ctrl.rxEnable = rxEnable_q;
   assign ctrl.nineBit = extFeature_q[UEF_EF_MULTIDROP];
   assign ctrl.loopback = specialFn_q[UEF_SF_LOOPBACK];
   assign ctrl.burstEnable = specialFn_q[UEF_SF_BURST];
   assign ctrl.autoDsrDtr = specialFn_q[UEF_SF_AUTO_DSR_DTR];
   assign ctrl.forceTx = specialFn_q[UEF_SF_FORCE_TX];
   assign ctrl.xtalFbDisable = specialFn_q[UEF_SF_XTAL_FB_DIS];
   assign ctrl.prescM = prescaler_q[UEF_PR_M_HI:UEF_PR_M_LO];
   assign ctrl.prescN = prescaler_q[UEF_PR_N_HI:UEF_PR_N_LO];
   assign ctrl.idleTime = idleTime_q;

   uef_dir_ctrl dirCtrl (
      .mclk(mclk),
      .rst_n(rst_n),
      .autoDir(extFeature_q[UEF_EF_AUTO_DIR]),
      .dirPol(extFeature_q[UEF_EF_DIR_POL]),
      .txDisable(extFeature_q[UEF_EF_TX_DIS]),
      .txActive(txActive),
      .txShiftBusy(txShiftBusy),
      .modemRts(modemRts),
      .rtsOut(rtsOut),
      .txStop(txStop)
   );

   uef_flow_status flowStat (
      .mclk(mclk),
      .rst_n(rst_n),
      .evt(flowEvt),
      .status(flowStatus)
   );
endmodule

// >>> rtl/uef_pkg.sv
// Constants and types for the UART extended-feature register set
// Overview of operation
// - IrDA bit picks 3/16 or 1/4 pulse
// - Polarity bit clear: RTS low transmitting
// - Polarity acts only with auto direction on
// - Auto direction bit gives RTS to transmitter
// - TX disable stops after shift register empties
// - RX disable bit stops serial reception
// - Multidrop bit selects 9-bit address/data framing
// - Special function reachable only when unlocked
// - Flow status gated; field 5:4 reports state
// - Remote-disable bit set after XOFF sent or RTS
// - Terminate bit set when remote stops transmitter
// - Prescaler N field feeds baud generator
// - RX level read-only, selected when bit6 clear
// - Error byte count read-only at offset 05
// - TX level read-only byte count
// - Bit 6 selects RX level or error count
// - Bit 4 allows burst access across registers
// - Bit 3 loops receive data to transmitter
// - Bit 2 opens prescaler and other registers
// - Bit 1 enables automatic DSR/DTR flow control
package uef_pkg;
   localparam logic [7:0] UEF_LCR_UNLOCK = 8'hBF;
   localparam logic [7:0] UEF_KEY_VALUE = 8'h5A;

   localparam logic [3:0] UEF_OFS_FLOW_STATUS = 4'h1;
   localparam logic [3:0] UEF_OFS_PRESCALER = 4'h4;
   localparam logic [3:0] UEF_OFS_RX_COUNT = 4'h5;
   localparam logic [3:0] UEF_OFS_TX_COUNT = 4'h6;
   localparam logic [3:0] UEF_OFS_SPECIAL_FN = 4'h7;
   localparam logic [3:0] UEF_OFS_IDLE_TIME = 4'h8;
   localparam logic [3:0] UEF_OFS_UNLOCK_KEY = 4'hD;
   localparam logic [3:0] UEF_OFS_EXT_FEATURE = 4'hF;

   localparam logic [7:0] UEF_RST_SPECIAL_FN = 8'h00;
   localparam logic [7:0] UEF_RST_IDLE_TIME = 8'h00;
   localparam logic [7:0] UEF_RST_UNLOCK_KEY = 8'h00;
   localparam logic [7:0] UEF_RST_EXT_FEATURE = 8'h00;
   localparam logic [7:0] UEF_RST_PRESCALER = 8'h10;

   // Writable bits of the extended feature control register
   localparam logic [7:0] UEF_EXT_FEATURE_MASK = 8'hB7;

   localparam int UEF_EF_IRDA_WIDE = 7;
   localparam int UEF_EF_DIR_POL = 5;
   localparam int UEF_EF_AUTO_DIR = 4;
   localparam int UEF_EF_TX_DIS = 2;
   localparam int UEF_EF_RX_DIS = 1;
   localparam int UEF_EF_MULTIDROP = 0;

   localparam int UEF_SF_XTAL_FB_DIS = 7;
   localparam int UEF_SF_CNT_SEL = 6;
   localparam int UEF_SF_BURST = 4;
   localparam int UEF_SF_LOOPBACK = 3;
   localparam int UEF_SF_SPECIAL_ACC = 2;
   localparam int UEF_SF_AUTO_DSR_DTR = 1;
   localparam int UEF_SF_FORCE_TX = 0;

   // Writable bits of the special function register
   localparam logic [7:0] UEF_SPECIAL_FN_MASK = 8'hDF;

   localparam int UEF_PR_M_HI = 7;
   localparam int UEF_PR_M_LO = 4;
   localparam int UEF_PR_N_HI = 3;
   localparam int UEF_PR_N_LO = 0;

   localparam logic [1:0] UEF_FLOW_IDLE = 2'h0;
   localparam logic [1:0] UEF_FLOW_XOFF_RCVD = 2'h1;
   localparam logic [1:0] UEF_FLOW_TX_OFF = 2'h2;
   localparam logic [1:0] UEF_FLOW_XON_RCVD = 2'h3;

   typedef struct packed {
      logic [7:0] rxCount;
      logic [7:0] errCount;
      logic [7:0] txCount;
   } uef_core_stat_t;

   typedef struct packed {
      logic xoffRcvd;
      logic xonRcvd;
      logic txOffSent;
      logic remoteHold;
      logic remoteTerm;
   } uef_flow_evt_t;

   typedef struct packed {
      logic irdaQuarter;
      logic rxEnable;
      logic nineBit;
      logic loopback;
      logic burstEnable;
      logic autoDsrDtr;
      logic forceTx;
      logic xtalFbDisable;
      logic [3:0] prescM;
      logic [3:0] prescN;
      logic [7:0] idleTime;
   } uef_ctrl_t;
endpackage

// >>> rtl/uef_dir_ctrl.sv
// RS-485 direction output and transmitter stop gate
`timescale 1ns/1ps
module uef_dir_ctrl (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic autoDir,
   input wire logic dirPol,
   input wire logic txDisable,
   input wire logic txActive,
   input wire logic txShiftBusy,
   input wire logic modemRts,
   output logic rtsOut,
   output logic txStop
);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rtsOut <= 1'b1;
      end else if (autoDir) begin
         rtsOut <= dirPol ? txActive : ~txActive;
      end else begin
         rtsOut <= modemRts;
      end
   end

   // Stop only at a character boundary
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         txStop <= 1'b0;
      end else if (!txDisable) begin
         txStop <= 1'b0;
      end else if (!txShiftBusy) begin
         txStop <= 1'b1;
      end
   end
endmodule

// >>> rtl/uef_flow_status.sv
// Software flow state tracker for the advanced flow status register
`timescale 1ns/1ps
module uef_flow_status
   import uef_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input uef_pkg::uef_flow_evt_t evt,
   output logic [7:0] status
);
   import uef_pkg::*;

   logic [1:0] state_q;
   logic remoteOff_q;
   logic term_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= UEF_FLOW_IDLE;
      end else if (evt.xoffRcvd) begin
         state_q <= UEF_FLOW_XOFF_RCVD;
      end else if (evt.xonRcvd) begin
         state_q <= UEF_FLOW_XON_RCVD;
      end else if (evt.txOffSent) begin
         state_q <= UEF_FLOW_TX_OFF;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         remoteOff_q <= 1'b0;
      end else begin
         remoteOff_q <= evt.txOffSent | evt.remoteHold | (remoteOff_q & ~evt.xonRcvd);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         term_q <= 1'b0;
      end else begin
         term_q <= evt.remoteTerm;
      end
   end

   assign status = {2'h0, state_q, 2'h0, remoteOff_q, term_q};
endmodule

// >>> verif/uef_remote_side.sv
// Remote line partner: flow events and transmit shift occupancy
`timescale 1ns/1ps
module uef_remote_side
   import uef_pkg::*;
(
   input wire logic mclk,
   input wire logic [4:0] req,
   input wire logic [3:0] frameLen,
   output uef_pkg::uef_flow_evt_t evt,
   output logic shiftBusy
);
   import uef_pkg::*;
   logic [3:0] left = 4'h0;
   always_ff @(posedge mclk) begin
      evt <= req;
      if (frameLen != 4'h0 && left == 4'h0) begin
         left <= frameLen;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   // Character stays in the shift register for frameLen cycles
   assign shiftBusy = left != 4'h0;
endmodule

// >>> verif/uef_ext_regs_checker.sv
// Concurrent checks on the extended-feature register port
`timescale 1ns/1ps
module uef_ext_regs_checker
   import uef_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] lineCtrl,
   input wire logic regSel,
   input wire logic regRd,
   input wire logic regWr,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic regRvalid,
   input uef_pkg::uef_core_stat_t coreStat,
   input uef_pkg::uef_flow_evt_t flowEvt,
   input wire logic txActive,
   input wire logic txShiftBusy,
   input wire logic modemRts,
   input uef_pkg::uef_ctrl_t ctrl,
   input wire logic rtsOut,
   input wire logic txStop
);
   import uef_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_read_answer: assert property (regSel && regRd |=> regRvalid)
      else $error("read not answered next cycle");
   a_valid_cause: assert property (regRvalid |-> $past(regSel && regRd))
      else $error("read valid without a read");
   a_rdata_hold: assert property ($changed(regRdata) && $past(rst_n) |-> regRvalid)
      else $error("read data moved without a read");
   a_locked_zero: assert property (
      regSel && regRd && lineCtrl != UEF_LCR_UNLOCK |=> regRdata == 8'h00)
      else $error("locked read returned data");
   a_ctrl_locked: assert property (
      $changed(ctrl) && $past(rst_n) |-> $past(regSel && regWr && lineCtrl == UEF_LCR_UNLOCK))
      else $error("control changed without unlocked write");
   a_rts_steady: assert property (
      $stable(txActive) && $stable(modemRts) && $past(rst_n) && !$past(regSel && regWr)
      |=> $stable(rtsOut))
      else $error("direction output moved without cause");
   a_stop_after_shift: assert property ($rose(txStop) |-> $past(!txShiftBusy))
      else $error("transmitter stopped mid character");
   a_stop_release: assert property (
      $fell(txStop) && $past(rst_n) |-> $past(regSel && regWr, 2))
      else $error("transmitter restarted without a write");
endmodule
bind uef_ext_regs uef_ext_regs_checker chk (.mclk(mclk), .rst_n(rst_n), .lineCtrl(lineCtrl),
   .regSel(regSel), .regRd(regRd), .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .regRvalid(regRvalid), .coreStat(coreStat), .flowEvt(flowEvt),
   .txActive(txActive), .txShiftBusy(txShiftBusy), .modemRts(modemRts), .ctrl(ctrl),
   .rtsOut(rtsOut), .txStop(txStop));

// >>> verif/uef_ext_regs_bench.sv
// Self-checking bench for the extended-feature register set
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module uef_ext_regs_bench;
   import uef_pkg::*;
   logic mclk = 0, rst_n = 0, regSel = 0, regRd = 0, regWr = 0, txActive = 0, modemRts = 0;
   logic [7:0] lineCtrl = 8'h00, regWdata = 8'h00, regRdata, rndData;
   logic [3:0] regAddr = 4'h0, frameLen = 4'h0, rndAddr;
   logic [4:0] req = 5'h00;
   logic regRvalid, rtsOut, txStop, txShiftBusy;
   uef_core_stat_t coreStat = '0;
   uef_flow_evt_t flowEvt;
   uef_ctrl_t ctrl;
   int fails = 0, checked = 0, ext = 0, sfn = 0, key = 0, prs = 8'h10, idl = 0, flw = 0, last = 0;
   bit inBurst = 0;
   logic [4:0] ev[5] = '{5'h10, 5'h04, 5'h08, 5'h02, 5'h01};
   logic [7:0] fx[5] = '{8'h10, 8'h22, 8'h30, 8'h32, 8'h33};
   always #4 mclk = ~mclk;
   uef_ext_regs uut (.mclk(mclk), .rst_n(rst_n), .lineCtrl(lineCtrl), .regSel(regSel),
      .regRd(regRd), .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .regRvalid(regRvalid), .coreStat(coreStat), .flowEvt(flowEvt), .txActive(txActive),
      .txShiftBusy(txShiftBusy), .modemRts(modemRts), .ctrl(ctrl), .rtsOut(rtsOut),
      .txStop(txStop));
   uef_remote_side far (.mclk(mclk), .req(req), .frameLen(frameLen), .evt(flowEvt),
      .shiftBusy(txShiftBusy));
   function automatic int mread(int a);
      bit u = lineCtrl == 8'hBF, s = u && sfn[2];
      case (a)
         1: return s ? flw : 0;
         4: return s ? prs : 0;
         5: return s ? (sfn[6] ? coreStat.errCount : coreStat.rxCount) : 0;
         6: return s ? coreStat.txCount : 0;
         7: return (u && key == 8'h5A) ? sfn : 0;
         8: return s ? idl : 0;
         13: return u ? key : 0;
         15: return (u && !sfn[2]) ? ext : 0;
         default: return 0;
      endcase
   endfunction
   task automatic mwrite(int a, int d);
      bit u = lineCtrl == 8'hBF, s = u && sfn[2];
      if (a == 13 && u) key = d;
      if (a == 7 && u && key == 8'h5A) sfn = d & 8'hDF;
      if (a == 15 && u && !sfn[2]) ext = d & 8'hB7;
      if (a == 4 && s) prs = d;
      if (a == 8 && s) idl = d;
   endtask
   // Strobes stay up between back-to-back accesses; idle drops them
   task automatic xfer(bit w, logic [3:0] a, logic [7:0] d);
      int e;
      e = (inBurst && sfn[4]) ? (last + 1) % 16 : a;
      regSel = 1;
      regRd = !w;
      regWr = w;
      regAddr = a;
      regWdata = d;
      @(negedge mclk);
      `CHK("rvalid", !w, regRvalid)
      if (w) mwrite(e, d);
      else `CHK("rdata", 8'(mread(e)), regRdata)
      last = e;
      inBurst = 1;
   endtask
   task idle();
      regSel = 0;
      regRd = 0;
      regWr = 0;
      inBurst = 0;
      @(negedge mclk);
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      xfer(1, a, d);
      idle();
   endtask
   task final_report();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      final_report();
   end
   initial begin
      void'($urandom(3675));
      repeat (20) @(negedge mclk);
      rst_n = 1;
      for (int i = 0; i < 200; i++) begin
         lineCtrl = $urandom_range(3) != 0 ? 8'hBF : 8'($urandom);
         coreStat = 24'($urandom);
         rndAddr = 4'($urandom);
         rndData = $urandom_range(1) ? 8'h5A : 8'($urandom);
         if (rndAddr == 4'h4) rndData[7:4] = 4'($urandom_range(2, 1));
         wr(rndAddr, rndData);
         `CHK("ctrl", {ext[7], !ext[1], ext[0], sfn[3], sfn[4], sfn[1], sfn[0], sfn[7], 8'(prs), 8'(idl)}, ctrl)
         xfer(0, 4'($urandom), 8'h00);
         idle();
      end
      $display("test random access done");
      lineCtrl = 8'hBF;
      wr(4'hD, 8'h5A);
      wr(4'h7, 8'h00);
      for (int i = 0; i < 16; i++) begin
         wr(4'hF, 8'({i[1:0], 4'h0}));
         txActive = i[2];
         modemRts = i[3];
         repeat (2) @(negedge mclk);
         `CHK("rts", ext[4] ? ext[5] == txActive : modemRts, rtsOut)
      end
      $display("test direction done");
      frameLen = 4'h6;
      @(negedge mclk);
      frameLen = 4'h0;
      wr(4'hF, 8'h04);
      `CHK("stop busy", 1'b0, txStop)
      for (int i = 0; i < 20 && txShiftBusy; i++) @(negedge mclk);
      repeat (2) @(negedge mclk);
      `CHK("stop", 1'b1, txStop)
      wr(4'hF, 8'h00);
      `CHK("stop clear", 1'b0, txStop)
      $display("test transmit stop done");
      wr(4'h7, 8'h04);
      for (int i = 0; i < 5; i++) begin
         req = ev[i];
         @(negedge mclk);
         if (i < 4) req = 5'h00;
         repeat (2) @(negedge mclk);
         flw = fx[i];
         xfer(0, 4'h1, 8'h00);
         idle();
      end
      req = 5'h00;
      xfer(0, 4'h5, 8'h00);
      idle();
      wr(4'h7, 8'h44);
      xfer(0, 4'h5, 8'h00);
      idle();
      $display("test flow status done");
      wr(4'h7, 8'h14);
      xfer(1, 4'h3, 8'h11);
      xfer(1, 4'h0, 8'h27);
      xfer(1, 4'h0, 8'h33);
      idle();
      xfer(0, 4'h6, 8'h00);
      xfer(0, 4'h0, 8'h00);
      xfer(0, 4'h0, 8'h00);
      idle();
      xfer(0, 4'h4, 8'h00);
      idle();
      $display("test burst done");
      final_report();
   end
endmodule
